// file: rtl/tcsp_timer_clock_select.sv
// Purpose: Clock control register and count-enable selection for timers 0 to 3.
// Assumes: Timers count on mclk and advance when their tick is high.
// Notes: Ticks are one-cycle enables, never derived clocks, so all timers stay on mclk.
`timescale 1ns/1ps
//Contract
// - Timer 3 high byte uses system clock when bit 7 set, else ext choice.
// - Timer 3 low/whole uses system clock when bit 6 set, else ext choice.
// - Timer 2 high byte uses system clock when bit 5 set, else ext choice.
// - Timer 2 low/whole uses system clock when bit 4 set, else ext choice.
// - Timer 1 uses prescaler when bit 3 clear, system clock when set.
// - Timer 1 select is ignored while Timer 1 counts external events.
// - Timer 0 uses prescaler when bit 2 clear, system clock when set.
// - Timer 0 select is ignored while Timer 0 counts external events.
// - Prescale codes 00, 01, 10 divide system clock by 12, 4, 48.
// - Code 11 divides external clock by 8, synchronised to system clock.
// - Control register is 8-bit read/write at 0x8E, reset zero, all pages.
module tcsp_timer_clock_select
  import tcsp_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Special-function register port.
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  output logic sfrHit,
  // Pin and timer configuration inputs.
  input wire logic extClkPin,
  input wire logic tmr0CounterModeSel,
  input wire logic tmr1CounterModeSel,
  input wire logic tmr2ExtClockTick,
  input wire logic tmr3ExtClockTick,
  // Count enables to the timers.
  output logic tmr0Tick,
  output logic tmr1Tick,
  output logic tmr2LowTick,
  output logic tmr2HighTick,
  output logic tmr3LowTick,
  output logic tmr3HighTick,
  // Register contents for observation.
  output logic [7:0] timerClockControl
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic sync1;
    logic sync2;
  } tcsp_top_st_t;

  tcsp_top_st_t st_ff;
  tcsp_top_st_t nxt_st;
  logic addrHit;
  tcsp_pre_if preLink();

  // The register sits at one address regardless of the page in use.
  assign addrHit = (sfrAddr == TCSP_CTRL_ADDR);
  assign sfrHit = addrHit;

  // Register update, read data capture and external-pin synchroniser.
  always_comb begin
    nxt_st = st_ff;
    if (sfrWrite && addrHit) begin
      nxt_st.ctrl = sfrWdata;
    end
    if (sfrRead) begin
      nxt_st.rdata = addrHit ? st_ff.ctrl : 8'h00;
    end
    // The second stage alone feeds the prescaler edge detector.
    nxt_st.sync1 = extClkPin;
    nxt_st.sync2 = st_ff.sync1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '{ctrl: TCSP_CTRL_RESET, rdata: 8'h00, sync1: 1'b0, sync2: 1'b0};
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign sfrRdata = st_ff.rdata;
  assign timerClockControl = st_ff.ctrl;
  assign preLink.preCode = st_ff.ctrl[TCSP_FLD_PRE_LO +: 2];
  assign preLink.extSync = st_ff.sync2;

  tcsp_prescaler uPre (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .pre(preLink.pre)
  );

  // Count-enable muxes; counter mode gates the timer 0/1 selections entirely, since
  // the timer then counts its own external events and needs no tick from here.
  always_comb begin
    tmr0Tick = 1'b0;
    tmr1Tick = 1'b0;
    if (!tmr0CounterModeSel) begin
      tmr0Tick = st_ff.ctrl[TCSP_BIT_T0] ? clkEn : preLink.preTick;
    end
    if (!tmr1CounterModeSel) begin
      tmr1Tick = st_ff.ctrl[TCSP_BIT_T1] ? clkEn : preLink.preTick;
    end
    tmr2LowTick = st_ff.ctrl[TCSP_BIT_T2L] ? clkEn : (clkEn & tmr2ExtClockTick);
    tmr2HighTick = st_ff.ctrl[TCSP_BIT_T2H] ? clkEn : (clkEn & tmr2ExtClockTick);
    tmr3LowTick = st_ff.ctrl[TCSP_BIT_T3L] ? clkEn : (clkEn & tmr3ExtClockTick);
    tmr3HighTick = st_ff.ctrl[TCSP_BIT_T3H] ? clkEn : (clkEn & tmr3ExtClockTick);
  end
endmodule : tcsp_timer_clock_select

// file: rtl/tcsp_pkg.sv
// Purpose: Constants and types for the timer clock select and prescaler block.
// Assumes: One system clock domain; special-function register port of 8 bits.
// Notes: Every offset, field position and division count, and the control and count reset values, live here.
package tcsp_pkg;
  // Register address and layout.
  localparam logic [7:0] TCSP_CTRL_ADDR = 8'h8E;
  localparam logic [7:0] TCSP_CTRL_RESET = 8'h00;
  localparam int TCSP_BIT_T3H = 7;
  localparam int TCSP_BIT_T3L = 6;
  localparam int TCSP_BIT_T2H = 5;
  localparam int TCSP_BIT_T2L = 4;
  localparam int TCSP_BIT_T1 = 3;
  localparam int TCSP_BIT_T0 = 2;
  localparam int TCSP_FLD_PRE_LO = 0;
  // Prescale codes.
  localparam logic [1:0] TCSP_PRE_DIV12 = 2'h0;
  localparam logic [1:0] TCSP_PRE_DIV4 = 2'h1;
  localparam logic [1:0] TCSP_PRE_DIV48 = 2'h2;
  localparam logic [1:0] TCSP_PRE_EXT8 = 2'h3;
  // Division counts.
  localparam logic [5:0] TCSP_DIV12 = 6'h0C;
  localparam logic [5:0] TCSP_DIV4 = 6'h04;
  localparam logic [5:0] TCSP_DIV48 = 6'h30;
  localparam logic [5:0] TCSP_DIV_EXT = 6'h08;
  localparam logic [5:0] TCSP_CNT_RESET = 6'h00;
endpackage : tcsp_pkg

// file: rtl/tcsp_pre_if.sv
// Purpose: Carries the prescaler control and tick between the top and the prescaler.
// Assumes: Same clock for both ends.
// Notes: The code travels top to prescaler; the tick comes back.
`timescale 1ns/1ps
interface tcsp_pre_if;
  logic [1:0] preCode;
  logic extSync;
  logic preTick;
  modport top (output preCode, output extSync, input preTick);
  modport pre (input preCode, input extSync, output preTick);
endinterface : tcsp_pre_if

// file: rtl/tcsp_prescaler.sv
// Purpose: Shared prescaler giving a one-cycle tick per divided period.
// Assumes: extSync is already synchronised to mclk.
// Notes: A code change restarts the count so the first period is never short.
`timescale 1ns/1ps
module tcsp_prescaler
  import tcsp_pkg::*;
(
  // Clock and control.
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // Link to the top.
  tcsp_pre_if.pre pre
);
  typedef struct packed {
    logic [5:0] cnt;
    logic [1:0] code;
    logic extPrev;
  } tcsp_pre_st_t;

  tcsp_pre_st_t st_ff;
  tcsp_pre_st_t nxt_st;
  logic [5:0] divisor;
  logic step;

  // Divisor and advance condition for the selected code.
  always_comb begin
    unique case (pre.preCode)
      TCSP_PRE_DIV12: divisor = TCSP_DIV12;
      TCSP_PRE_DIV4: divisor = TCSP_DIV4;
      TCSP_PRE_DIV48: divisor = TCSP_DIV48;
      TCSP_PRE_EXT8: divisor = TCSP_DIV_EXT;
    endcase
    // External mode advances only on a rising edge of the synced clock.
    step = (pre.preCode == TCSP_PRE_EXT8) ? (pre.extSync & ~st_ff.extPrev) : 1'b1;
  end

  // Counter next state; tick fires when the count wraps.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.extPrev = pre.extSync;
    nxt_st.code = pre.preCode;
    if (pre.preCode != st_ff.code) begin
      nxt_st.cnt = TCSP_CNT_RESET;
    end else if (step) begin
      nxt_st.cnt = (st_ff.cnt + 6'h01 >= divisor) ? TCSP_CNT_RESET : st_ff.cnt + 6'h01;
    end
  end

  assign pre.preTick = clkEn && step && (pre.preCode == st_ff.code)
                       && (st_ff.cnt + 6'h01 >= divisor);

  // State register, frozen while the clock enable is low.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end
endmodule : tcsp_prescaler

// file: bench/tcsp_checker.sv
// Purpose: Port checks for the timer clock select block.
// Assumes: One clock; reset synchronous, active high.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
module tcsp_checker (
  // Clock and register side.
  input wire logic mclk, rst, clkEn, sfrWrite, sfrHit,
  input wire logic [7:0] sfrWdata, timerClockControl,
  // Selections and ticks.
  input wire logic tmr0CounterModeSel, tmr1CounterModeSel, tmr2ExtClockTick, tmr3ExtClockTick,
  input wire logic tmr0Tick, tmr1Tick, tmr2LowTick, tmr2HighTick, tmr3LowTick, tmr3HighTick
);
  logic [7:0] c;
  // Short alias keeps each property but a_t0_shared_pre on one line.
  assign c = timerClockControl;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_t3h_sys: assert property (clkEn && c[7] |-> tmr3HighTick)
    else $error("t3 high tick");
  a_t3l_ext: assert property (clkEn && !c[6] |-> tmr3LowTick == tmr3ExtClockTick)
    else $error("t3 low tick");
  a_t2h_ext: assert property (clkEn && !c[5] |-> tmr2HighTick == tmr2ExtClockTick)
    else $error("t2 high tick");
  a_t2l_sys: assert property (clkEn && c[4] |-> tmr2LowTick)
    else $error("t2 low tick");
  a_t1_sys: assert property (clkEn && c[3] && !tmr1CounterModeSel |-> tmr1Tick)
    else $error("t1 tick");
  a_t1_event_mode: assert property (tmr1CounterModeSel |-> !tmr1Tick)
    else $error("t1 not ignored");
  a_t0_shared_pre: assert property (c[3:2] == 2'h0 && !tmr0CounterModeSel
    && !tmr1CounterModeSel |-> tmr0Tick == tmr1Tick)
    else $error("t0 prescale tick");
  a_t0_event_mode: assert property (tmr0CounterModeSel |-> !tmr0Tick)
    else $error("t0 not ignored");
  a_write_lands: assert property (clkEn && sfrWrite && sfrHit |=> c == $past(sfrWdata))
    else $error("write lost");
endmodule : tcsp_checker
bind tcsp_timer_clock_select tcsp_checker chkI (.*);

// file: bench/tcsp_timer_sink.sv
// Purpose: Timer 1 counter fed by its count enable.
// Assumes: Ticks are one-cycle enables on mclk.
// Notes: Counts only; no reload or overflow.
`timescale 1ns/1ps
module tcsp_timer_sink (
  // Clock and tick in.
  input wire logic mclk,
  input wire logic tick,
  // Running total out.
  output int total = 0
);
  // An unknown tick is not counted, so it shows as a short total.
  always @(posedge mclk) begin
    if (tick === 1'b1) begin
      total <= total + 1;
    end
  end
endmodule : tcsp_timer_sink

// file: bench/tcsp_timer_clock_select_tb_top.sv
// Purpose: Self-checking bench for the timer clock select block.
// Assumes: Inputs other than the pin move 1 ns after each rising edge.
// Notes: The pin rises every 260 ns, so eight rises span 52 cycles.
`timescale 1ns/1ps
module tcsp_timer_clock_select_tb_top;
  import tcsp_pkg::*;
  logic mclk = 0, rst = 1, clkEn = 1, sfrWrite = 0, sfrRead = 0, extClkPin = 0, sfrHit;
  logic m0 = 0, m1 = 0, e2 = 0, e3 = 0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, ctl;
  // Six separate output ports drive the bits, so this must be a net, not a variable.
  wire [5:0] ticks;
  int err_total = 0, checks_done = 0, g, base, total;
  int divTab [4] = '{12, 4, 48, 52};
  // Pin phase avoids the rising mclk edges on its rises.
  always #20 mclk = ~mclk;
  always #130 extClkPin = ~extClkPin;
  tcsp_timer_clock_select DUT (.mclk(mclk), .rst(rst), .clkEn(clkEn), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .sfrHit(sfrHit), .extClkPin(extClkPin), .tmr0CounterModeSel(m0), .tmr1CounterModeSel(m1),
    .tmr2ExtClockTick(e2), .tmr3ExtClockTick(e3), .tmr0Tick(ticks[0]), .tmr1Tick(ticks[1]),
    .tmr2LowTick(ticks[2]), .tmr2HighTick(ticks[3]), .tmr3LowTick(ticks[4]),
    .tmr3HighTick(ticks[5]), .timerClockControl(ctl));
  tcsp_timer_sink sink (.mclk(mclk), .tick(ticks[1]), .total(total));
  task step;
    @(posedge mclk);
    #1;
  endtask : step
  task chk(string n, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", n, exp, seen);
      err_total++;
    end
  endtask : chk
  task acc(logic [7:0] a, logic [7:0] d, logic w);
    sfrAddr = a;
    sfrWdata = d;
    {sfrWrite, sfrRead} = {w, !w};
    step;
    {sfrWrite, sfrRead} = 2'h0;
  endtask : acc
  // Cycles between two timer 0 ticks, bounded.
  task gap;
    for (g = 0; g < 200 && ticks[0] !== 1'b1; g++) step;
    g = 0;
    do begin
      step;
      g++;
    end while (g < 200 && ticks[0] !== 1'b1);
  endtask : gap
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Main sequence; the model register mv tracks accepted writes.
  initial begin : main
    logic [7:0] v, a, b, mv;
    logic [5:0] x, mask;
    mv = 8'($urandom(83360));
    mv = TCSP_CTRL_RESET;
    repeat (10) @(posedge mclk);
    #1 rst = 0;
    acc(TCSP_CTRL_ADDR, 8'h00, 0);
    chk("reset", sfrRdata, 8'h00);
    for (int k = 0; k < 4; k++) begin
      acc(TCSP_CTRL_ADDR, 8'(k), 1);
      gap;
      chk("gap", 8'(g), 8'(divTab[k]));
    end
    acc(TCSP_CTRL_ADDR, 8'h08, 1);
    base = total;
    repeat (20) step;
    chk("t1count", 8'(total - base), 8'h14);
    repeat (60) begin
      v = 8'($urandom);
      a = $urandom % 2 ? TCSP_CTRL_ADDR : 8'($urandom);
      b = $urandom % 2 ? TCSP_CTRL_ADDR : 8'($urandom);
      acc(a, v, 1);
      mv = a === TCSP_CTRL_ADDR ? v : mv;
      acc(b, 8'h00, 0);
      chk("rdata", sfrRdata, b === TCSP_CTRL_ADDR ? mv : 8'h00);
      chk("ctl", ctl, mv);
      chk("hit", {7'h00, sfrHit}, {7'h00, b === TCSP_CTRL_ADDR});
      {clkEn, m0, m1, e2, e3} = 5'($urandom);
      #4;
      x = clkEn ? {mv[7] | e3, mv[6] | e3, mv[5] | e2, mv[4] | e2, !m1 & mv[3], !m0 & mv[2]} : 6'h00;
      mask = {4'hF, m1 | mv[3], m0 | mv[2]};
      chk("ticks", {2'h0, ticks & mask}, {2'h0, x & mask});
      step;
      clkEn = 1;
    end
    print_verdict;
  end
  // Watchdog far beyond the expected run.
  initial begin
    #200000;
    err_total++;
    print_verdict;
  end
endmodule : tcsp_timer_clock_select_tb_top
